//--- rtl/tcs_pkg.sv
// constants and types shared by the tail-cancelling shaper
package tcs_pkg;
    localparam int SAMPLE_W  = 10;
    localparam int FRAC_EXT  = 2;
    localparam int DATA_W    = SAMPLE_W + FRAC_EXT;
    localparam int ARITH_W   = 13;
    localparam int COEF_W    = 13;
    localparam int COEF_FRAC = 11;
    localparam int ACC_W     = 30;
    localparam int N_SECT    = 4;
    localparam int N_COEF    = 2 * N_SECT;
    localparam int IDX_W     = 3;
    localparam int N_CH_DEF  = 32;
    localparam int LATENCY   = 2;

    // coefficient index map: zeros first, then poles
    localparam logic [IDX_W-1:0] ZERO_IDX_1 = 3'h0;
    localparam logic [IDX_W-1:0] ZERO_IDX_2 = 3'h1;
    localparam logic [IDX_W-1:0] ZERO_IDX_3 = 3'h2;
    localparam logic [IDX_W-1:0] ZERO_IDX_4 = 3'h3;
    localparam logic [IDX_W-1:0] POLE_IDX_1 = 3'h4;
    localparam logic [IDX_W-1:0] POLE_IDX_2 = 3'h5;
    localparam logic [IDX_W-1:0] POLE_IDX_3 = 3'h6;
    localparam logic [IDX_W-1:0] POLE_IDX_4 = 3'h7;

    localparam logic [ARITH_W-1:0]  STATE_RST  = 13'h0000;
    localparam logic [COEF_W-1:0]   COEF_RST   = 13'h0000;
    localparam logic [SAMPLE_W-1:0] SAMPLE_MAX = 10'h3ff;
    localparam logic [ARITH_W-1:0]  ROUND_HALF = 13'h0002;

    typedef logic signed [ARITH_W-1:0]  tcs_word_t;
    typedef logic signed [COEF_W-1:0]   tcs_coef_t;
    typedef logic signed [ACC_W-1:0]    tcs_acc_t;
    typedef logic [SAMPLE_W-1:0]        tcs_sample_t;
    typedef logic [IDX_W-1:0]           tcs_idx_t;
    typedef tcs_coef_t [N_COEF-1:0]     tcs_coef_set_t;
    typedef tcs_word_t [N_SECT-1:0]     tcs_state_t;

    typedef struct packed {
        tcs_word_t y;
        tcs_word_t s_a;
        tcs_word_t s_b;
    } tcs_pair_t;
endpackage

//--- rtl/tcs_coef_if.sv
// coefficient store link between filter core and coefficient memory
`timescale 1ns/1ps
interface tcs_coef_if #(
    parameter int N_CH = tcs_pkg::N_CH_DEF
);
    import tcs_pkg::*;
    localparam int CH_W = (N_CH > 1) ? $clog2(N_CH) : 1;

    logic [CH_W-1:0] flt_ch;
    tcs_coef_set_t   flt_coef;
    logic            cfg_we;
    logic [CH_W-1:0] cfg_ch;
    tcs_idx_t        cfg_idx;
    tcs_coef_t       cfg_wdata;
    tcs_coef_t       cfg_rdata;

    modport mem (
        input  flt_ch,
        input  cfg_we,
        input  cfg_ch,
        input  cfg_idx,
        input  cfg_wdata,
        output flt_coef,
        output cfg_rdata
    );
    modport user (
        output flt_ch,
        output cfg_we,
        output cfg_ch,
        output cfg_idx,
        output cfg_wdata,
        input  flt_coef,
        input  cfg_rdata
    );
endinterface

//--- rtl/tcs_coef_mem.sv
// per-channel coefficient memory with registered read ports
`timescale 1ns/1ps
module tcs_coef_mem #(
    parameter int N_CH = tcs_pkg::N_CH_DEF
) (
    input  wire logic mclk,
    input  wire logic rst,
    tcs_coef_if.mem   cif
);
    import tcs_pkg::*;

    tcs_coef_set_t mem [N_CH];
    tcs_coef_set_t next_entry;

    always_comb begin
        next_entry = mem[cif.cfg_ch];
        next_entry[cif.cfg_idx] = cif.cfg_wdata;
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            for (int i = 0; i < N_CH; i++) begin
                mem[i] <= {N_COEF{COEF_RST}};
            end
            cif.flt_coef  <= {N_COEF{COEF_RST}};
            cif.cfg_rdata <= COEF_RST;
        end else begin
            if (cif.cfg_we) begin
                mem[cif.cfg_ch] <= next_entry;
            end
            cif.flt_coef  <= mem[cif.flt_ch];
            cif.cfg_rdata <= mem[cif.cfg_ch][cif.cfg_idx];
        end
    end

    stored_write_a:
    assert property (@(posedge mclk) disable iff (rst)
        cif.cfg_we |=> mem[$past(cif.cfg_ch)][$past(cif.cfg_idx)] == $past(cif.cfg_wdata))
    else $error("coefficient write not stored for its channel");

    write_readback_a:
    assert property (@(posedge mclk) disable iff (rst)
        (cif.cfg_we ##1 (!cif.cfg_we && cif.cfg_ch == $past(cif.cfg_ch)
            && cif.cfg_idx == $past(cif.cfg_idx)))
        |=> cif.cfg_rdata == $past(cif.cfg_wdata, 2))
    else $error("coefficient read back differs from written value");
endmodule

//--- rtl/tcs_shaper.sv
// fourth-order tail-cancelling IIR shaper, time-shared over channels
`timescale 1ns/1ps

module tcs_shaper #(
    parameter int N_CH = tcs_pkg::N_CH_DEF,
    parameter int CH_W = (N_CH > 1) ? $clog2(N_CH) : 1
) (
    input  wire logic            mclk,
    input  wire logic            rst,
    input  wire logic            in_valid,
    input  wire logic [CH_W-1:0] in_ch,
    input  wire tcs_pkg::tcs_sample_t in_sample,
    input  wire logic [1:0]      pair_mode,
    input  wire logic            cfg_we,
    input  wire logic [CH_W-1:0] cfg_ch,
    input  wire tcs_pkg::tcs_idx_t  cfg_idx,
    input  wire tcs_pkg::tcs_coef_t cfg_wdata,
    output tcs_pkg::tcs_coef_t   cfg_rdata,
    output logic                 out_valid,
    output logic [CH_W-1:0]      out_ch,
    output tcs_pkg::tcs_sample_t out_sample
);
    import tcs_pkg::*;

    // saturate a wide sum to the section word
    function automatic tcs_word_t sat_w(input tcs_acc_t v);
        tcs_acc_t hi;
        tcs_acc_t lo;
        hi = ACC_W'(2 ** (ARITH_W - 1) - 1);
        lo = -hi - ACC_W'(1);
        if (v > hi) begin
            return tcs_word_t'(hi[ARITH_W-1:0]);
        end else if (v < lo) begin
            return tcs_word_t'(lo[ARITH_W-1:0]);
        end
        return v[ARITH_W-1:0];
    endfunction

    function automatic tcs_acc_t ext(input tcs_word_t v);
        return ACC_W'(v);
    endfunction

    // coefficient times word, scaled back to word units
    function automatic tcs_acc_t mulc(input tcs_coef_t c, input tcs_word_t v);
        tcs_acc_t p;
        p = ACC_W'(c) * ACC_W'(v);
        return p >>> COEF_FRAC;
    endfunction

    // two sections: either two first-order stages or one biquad
    function automatic tcs_pair_t run_pair(
        input logic      biquad,
        input tcs_word_t x,
        input tcs_word_t s_a,
        input tcs_word_t s_b,
        input tcs_coef_t za,
        input tcs_coef_t pa,
        input tcs_coef_t zb,
        input tcs_coef_t pb
    );
        tcs_pair_t r;
        tcs_word_t ya;
        r  = '0;
        ya = sat_w(ext(x) + ext(s_a));
        if (biquad) begin
            r.y   = ya;
            r.s_a = sat_w(ext(s_b) + mulc(pa, ya) - mulc(za, x));
            r.s_b = sat_w(mulc(pb, ya) - mulc(zb, x));
        end else begin
            r.y   = sat_w(ext(ya) + ext(s_b));
            r.s_a = sat_w(mulc(pa, ya) - mulc(za, x));
            r.s_b = sat_w(mulc(pb, r.y) - mulc(zb, ya));
        end
        return r;
    endfunction

    // drop the extra fraction bits with rounding, clamp to sample range
    function automatic tcs_sample_t to_out(input tcs_word_t y);
        tcs_acc_t r;
        // sum stays signed so negative results clamp to zero
        r = (ext(y) + ext(tcs_word_t'(ROUND_HALF))) >>> FRAC_EXT;
        if (r < 0) begin
            return '0;
        end else if (r > ACC_W'(SAMPLE_MAX)) begin
            return SAMPLE_MAX;
        end
        return r[SAMPLE_W-1:0];
    endfunction

    tcs_coef_if #(.N_CH(N_CH)) cif ();

    tcs_coef_mem #(.N_CH(N_CH)) tcs_coef_mem_i (
        .mclk (mclk),
        .rst  (rst),
        .cif  (cif.mem)
    );

    assign cif.flt_ch    = in_ch;
    assign cif.cfg_we    = cfg_we;
    assign cif.cfg_ch    = cfg_ch;
    assign cif.cfg_idx   = cfg_idx;
    assign cif.cfg_wdata = cfg_wdata;
    assign cfg_rdata     = cif.cfg_rdata;

    // stage 1: sample aligned with its channel's coefficients
    logic            v1;
    logic [CH_W-1:0] ch1;
    tcs_word_t       x1;
    logic            next_v1;
    logic [CH_W-1:0] next_ch1;
    tcs_word_t       next_x1;

    always_comb begin
        next_v1  = in_valid;
        next_ch1 = in_ch;
        next_x1  = tcs_word_t'({1'b0, in_sample, {FRAC_EXT{1'b0}}});
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            v1  <= 1'b0;
            ch1 <= '0;
            x1  <= STATE_RST;
        end else begin
            v1  <= next_v1;
            ch1 <= next_ch1;
            x1  <= next_x1;
        end
    end

    // stage 2: four-section cascade and per-channel state
    tcs_state_t    st [N_CH];
    tcs_state_t    row;
    tcs_state_t    next_row;
    tcs_coef_set_t cf;
    tcs_pair_t     p0;
    tcs_pair_t     p1;
    logic          next_out_valid;
    logic [CH_W-1:0] next_out_ch;
    tcs_sample_t   next_out_sample;
    logic          idle_path;

    always_comb begin
        row = st[ch1];
        cf  = cif.flt_coef;
        p0  = run_pair(pair_mode[0], x1, row[0], row[1],
                       cf[ZERO_IDX_1], cf[POLE_IDX_1],
                       cf[ZERO_IDX_2], cf[POLE_IDX_2]);
        p1  = run_pair(pair_mode[1], p0.y, row[2], row[3],
                       cf[ZERO_IDX_3], cf[POLE_IDX_3],
                       cf[ZERO_IDX_4], cf[POLE_IDX_4]);
        next_row        = {p1.s_b, p1.s_a, p0.s_b, p0.s_a};
        next_out_valid  = v1;
        next_out_ch     = v1 ? ch1 : out_ch;
        next_out_sample = v1 ? to_out(p1.y) : out_sample;
        idle_path       = (cf == {N_COEF{COEF_RST}}) && (row == {N_SECT{STATE_RST}});
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            for (int i = 0; i < N_CH; i++) begin
                st[i] <= {N_SECT{STATE_RST}};
            end
            out_valid  <= 1'b0;
            out_ch     <= '0;
            out_sample <= '0;
        end else begin
            if (v1) begin
                st[ch1] <= next_row;
            end
            out_valid  <= next_out_valid;
            out_ch     <= next_out_ch;
            out_sample <= next_out_sample;
        end
    end

    fixed_latency_a:
    assert property (@(posedge mclk) disable iff (rst)
        ##2 out_valid == $past(in_valid, 2))
    else $error("output valid not two cycles after input valid");

    channel_follow_a:
    assert property (@(posedge mclk) disable iff (rst)
        in_valid |-> ##2 (out_valid && out_ch == $past(in_ch, 2)))
    else $error("output channel does not match input channel");

    zero_passthru_a:
    assert property (@(posedge mclk) disable iff (rst)
        (v1 && idle_path) |=> out_sample == $past(in_sample, 2))
    else $error("zero coefficients did not pass sample unchanged");

    state_hold_a:
    assert property (@(posedge mclk) disable iff (rst)
        !v1 |=> st[0] == $past(st[0]))
    else $error("section state changed without a valid sample");

    other_channel_a:
    assert property (@(posedge mclk) disable iff (rst)
        (v1 && ch1 != '0) |=> $stable(st[0]))
    else $error("state of an idle channel was disturbed");

    reset_clear_a:
    assert property (@(posedge mclk)
        rst |=> (!out_valid && st[0] == {N_SECT{STATE_RST}} && out_sample == '0))
    else $error("reset did not clear output and state");

    result_hold_a:
    assert property (@(posedge mclk) disable iff (rst)
        !v1 |=> ($stable(out_ch) && $stable(out_sample)))
    else $error("output changed without a new result");
endmodule

//--- sim/tcs_sink_model.sv
// downstream baseline stage model: counts results and keeps the last one
`timescale 1ns/1ps
module tcs_sink_model (
    input wire logic                 mclk,
    input wire logic                 rst,
    input wire logic                 out_valid,
    input wire tcs_pkg::tcs_sample_t out_sample
);
    import tcs_pkg::*;
    int          count;
    tcs_sample_t last;
    always_ff @(posedge mclk) begin
        if (rst) begin
            count <= 0;
        end else if (out_valid) begin
            count <= count + 1;
            last  <= out_sample;
        end
    end
endmodule

//--- sim/tcs_shaper_tb.sv
// self-checking bench for the tail-cancelling shaper
`timescale 1ns/1ps
module tcs_shaper_tb;
    import tcs_pkg::*;
    logic        mclk = 0;
    logic        rst = 1;
    logic        in_valid = 0;
    logic [4:0]  in_ch = 0;
    tcs_sample_t in_sample = 0;
    logic [1:0]  pair_mode = 0;
    logic        cfg_we = 0;
    logic [4:0]  cfg_ch = 0;
    tcs_idx_t    cfg_idx = 0;
    tcs_coef_t   cfg_wdata = 0;
    tcs_coef_t   cfg_rdata;
    logic        out_valid;
    logic [4:0]  out_ch;
    tcs_sample_t out_sample;
    int          err_count = 0;
    int          tests_run = 0;
    int          sent = 0;

    always #5 mclk = ~mclk;

    tcs_shaper tcs_shaper_i (
        .mclk      (mclk),
        .rst       (rst),
        .in_valid  (in_valid),
        .in_ch     (in_ch),
        .in_sample (in_sample),
        .pair_mode (pair_mode),
        .cfg_we    (cfg_we),
        .cfg_ch    (cfg_ch),
        .cfg_idx   (cfg_idx),
        .cfg_wdata (cfg_wdata),
        .cfg_rdata (cfg_rdata),
        .out_valid (out_valid),
        .out_ch    (out_ch),
        .out_sample(out_sample)
    );
    tcs_sink_model tcs_sink_model_i (
        .mclk      (mclk),
        .rst       (rst),
        .out_valid (out_valid),
        .out_sample(out_sample)
    );

    task automatic check(input logic [12:0] seen, input logic [12:0] exp);
        tests_run++;
        if (seen !== exp) begin
            err_count++;
            $display("MISMATCH at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic wr(input logic [4:0] c, input tcs_idx_t i, input tcs_coef_t d);
        @(negedge mclk);
        cfg_we = 1;
        cfg_ch = c;
        cfg_idx = i;
        cfg_wdata = d;
        @(negedge mclk);
        cfg_we = 0;
        @(negedge mclk);
        check(cfg_rdata, d);
    endtask

    task automatic send(input logic [4:0] c, input tcs_sample_t s, input tcs_sample_t e);
        @(negedge mclk);
        in_valid = 1;
        in_ch = c;
        in_sample = s;
        sent++;
        @(negedge mclk);
        in_valid = 0;
        @(negedge mclk);
        check(13'(out_valid), 13'h0001);
        check(13'(out_ch), 13'(c));
        check(13'(out_sample), 13'(e));
        @(negedge mclk);
        check(13'(out_valid), 13'h0000);
    endtask

    task automatic t_reset;
        check(13'(out_valid), 13'h0000);
        check(13'(out_sample), 13'h0000);
        check(cfg_rdata, 13'h0000);
        $display("test reset done");
    endtask

    task automatic t_coefs;
        for (int i = 0; i < 8; i++) begin
            wr(5'h1f, 3'(i), 13'(i * 3 + 1));
        end
        for (int i = 0; i < 8; i++) begin
            wr(5'h1e, 3'(i), 13'h1f00 + 13'(i));
        end
        for (int i = 0; i < 8; i++) begin
            @(negedge mclk);
            cfg_ch = 5'h1f;
            cfg_idx = 3'(i);
            @(negedge mclk);
            check(cfg_rdata, 13'(i * 3 + 1));
        end
        $display("test coefficient store done");
    endtask

    task automatic t_sections;
        send(5'h00, 10'h123, 10'h123);
        wr(5'h01, ZERO_IDX_1, 13'h0800);
        send(5'h01, 10'h064, 10'h064);
        send(5'h01, 10'h064, 10'h000);
        wr(5'h02, POLE_IDX_1, 13'h0400);
        send(5'h02, 10'h190, 10'h190);
        send(5'h02, 10'h000, 10'h0c8);
        send(5'h00, 10'h064, 10'h064);
        $display("test single section done");
    endtask

    task automatic t_cascade;
        wr(5'h03, ZERO_IDX_1, 13'h0800);
        wr(5'h03, ZERO_IDX_2, 13'h0800);
        send(5'h03, 10'h064, 10'h064);
        send(5'h03, 10'h064, 10'h000);
        send(5'h03, 10'h064, 10'h000);
        $display("test cascade done");
    endtask

    task automatic t_saturate;
        wr(5'h04, ZERO_IDX_4, 13'h1800);
        send(5'h04, 10'h3e8, 10'h3e8);
        send(5'h04, 10'h3e8, 10'h3ff);
        $display("test saturation done");
    endtask

    // exponential tail streamed back to back, cancelled by one zero
    task automatic t_tail;
        tcs_sample_t smp [4] = '{10'h190, 10'h0c8, 10'h064, 10'h032};
        tcs_sample_t res [4] = '{10'h190, 10'h000, 10'h000, 10'h000};
        wr(5'h05, ZERO_IDX_1, 13'h0400);
        wr(5'h05, ZERO_IDX_4, 13'h0000);
        wr(5'h05, POLE_IDX_4, 13'h0000);
        for (int i = 0; i < 6; i++) begin
            @(negedge mclk);
            if (i >= 2) begin
                check(13'(out_valid), 13'h0001);
                check(13'(out_sample), 13'(res[i-2]));
            end
            in_valid = (i < 4);
            if (i < 4) begin
                in_ch = 5'h05;
                in_sample = smp[i];
                sent++;
            end
        end
        $display("test tail cancel done");
    endtask

    task automatic t_midreset;
        @(negedge mclk);
        rst = 1;
        sent = 0;
        repeat (2) @(negedge mclk);
        rst = 0;
        check(13'(out_valid), 13'h0000);
        check(13'(out_sample), 13'h0000);
        check(cfg_rdata, 13'h0000);
        cfg_ch = 5'h1f;
        cfg_idx = POLE_IDX_1;
        @(negedge mclk);
        check(cfg_rdata, 13'h0000);
        send(5'h02, 10'h190, 10'h190);
        send(5'h02, 10'h000, 10'h000);
        $display("test mid-run reset done");
    endtask

    // both pairs as biquads: y = x + 0.5 y[n-2] twice
    task automatic t_biquad;
        wr(5'h06, POLE_IDX_2, 13'h0400);
        wr(5'h06, POLE_IDX_4, 13'h0400);
        pair_mode = 2'b11;
        send(5'h06, 10'h190, 10'h190);
        send(5'h06, 10'h000, 10'h000);
        send(5'h06, 10'h000, 10'h190);
        pair_mode = 2'b00;
        $display("test biquad pairs done");
    endtask

    task automatic close_out;
        $display("comparisons %0d mismatches %0d", tests_run, err_count);
        if (err_count == 0 && tests_run > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    initial begin
        repeat (10) @(negedge mclk);
        rst = 0;
        t_reset();
        t_coefs();
        t_sections();
        t_cascade();
        t_saturate();
        t_tail();
        t_midreset();
        t_biquad();
        @(negedge mclk);
        check(13'(tcs_sink_model_i.count), 13'(sent));
        check(13'(tcs_sink_model_i.last), 13'h0190);
        close_out();
    end
endmodule
